// ==== hw/cce_exec.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Execution of call, memory clears and watchdog clears
// ----------------------------------------------------------------
module cce_exec
(
    // Clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       rst_b,
    // Decoded operation and its operands
    input  wire logic                       opValid,
    input  wire cce_pkg::cce_op_e           opCode,
    input  wire logic [cce_pkg::PC_W-1:0]   curPc,
    input  wire logic [cce_pkg::PC_W-1:0]   callTarget,
    input  wire logic [cce_pkg::ADDR_W-1:0] memAddr,
    input  wire logic [cce_pkg::BIT_W-1:0]  bitSel,
    input  wire logic [cce_pkg::DATA_W-1:0] memRdata,
    // Stall, return-address stack and program counter
    output logic                            busy,
    output logic                            stackPush,
    output logic [cce_pkg::PC_W-1:0]        stackData,
    output logic                            pcLoad,
    output logic [cce_pkg::PC_W-1:0]        pcValue,
    // Data memory write
    output logic                            memWe,
    output logic [cce_pkg::ADDR_W-1:0]      memWaddr,
    output logic [cce_pkg::DATA_W-1:0]      memWdata,
    // Watchdog restart and status flag clears
    output logic                            wdtRestart,
    output logic                            clrTimeoutFlag,
    output logic                            clrPowerdownFlag
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    cce_pkg::cce_state_e             state_q,  state_d;   // Execution phase
    cce_pkg::cce_pair_e              pair_q,   pair_d;    // Last paired clear
    logic                            push_q,   push_d;    // Stack push strobe
    logic [cce_pkg::PC_W-1:0]        stk_q,    stk_d;     // Return point
    logic                            pcl_q,    pcl_d;     // PC load strobe
    logic [cce_pkg::PC_W-1:0]        pcv_q,    pcv_d;     // Jump target
    logic [cce_pkg::PC_W-1:0]        tgt_q,    tgt_d;     // Target held over
    logic                            we_q,     we_d;      // Memory write
    logic [cce_pkg::ADDR_W-1:0]      wa_q,     wa_d;      // Write address
    logic [cce_pkg::DATA_W-1:0]      wd_q,     wd_d;      // Write data
    logic                            wdt_q,    wdt_d;     // Watchdog clear
    logic                            accept;              // Op taken now

    // Decode ignores new ops while the call finishes its second cycle;
    // fetch must hold off on busy, since a dropped op is not replayed
    assign accept = opValid && (state_q == cce_pkg::ST_EXEC);
    // Busy comes straight from the state so fetch sees the stall
    // in the same cycle as the push
    assign busy   = (state_q == cce_pkg::ST_CALL2);

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    // Every strobe defaults low so each lasts exactly one cycle; data
    // registers keep their last value so the outputs stay steady
    always_comb
    begin
        state_d = cce_pkg::ST_EXEC;
        pair_d  = pair_q;
        push_d  = 1'b0;
        stk_d   = stk_q;
        pcl_d   = 1'b0;
        pcv_d   = pcv_q;
        tgt_d   = tgt_q;
        we_d    = 1'b0;
        wa_d    = wa_q;
        wd_d    = wd_q;
        wdt_d   = 1'b0;
        if (state_q == cce_pkg::ST_CALL2)
        begin
            // Second cycle: jump to target
            pcl_d = 1'b1;
            pcv_d = tgt_q;
        end
        else if (accept)
        begin
            // Operation taken at this edge
            case (opCode)
                cce_pkg::OP_CALL:
                begin
                    // No condition checked at all
                    state_d = cce_pkg::ST_CALL2;
                    push_d  = 1'b1;
                    stk_d   = curPc + cce_pkg::RET_INC;
                    tgt_d   = callTarget;
                end
                cce_pkg::OP_CLR_BYTE:
                begin
                    // Whole byte written as zero
                    we_d = 1'b1;
                    wa_d = memAddr;
                    wd_d = cce_pkg::BYTE_ZERO;
                end
                cce_pkg::OP_CLR_BIT:
                begin
                    // Read-modify-write keeps the other bits
                    // The byte is read in the take cycle, so one cycle will do
                    we_d = 1'b1;
                    wa_d = memAddr;
                    wd_d = memRdata & ~(cce_pkg::DATA_W'(1) << bitSel);
                end
                cce_pkg::OP_WDT_ONE:
                begin
                    // Single clear needs no pairing
                    wdt_d = 1'b1;
                end
                cce_pkg::OP_WDT_P1:
                begin
                    // Effective only after the second of the pair
                    // Pair memory moves on even when no pulse is given
                    if (pair_q == cce_pkg::PAIR_SECOND)
                    begin
                        wdt_d = 1'b1;
                    end
                    pair_d = cce_pkg::PAIR_FIRST;
                end
                cce_pkg::OP_WDT_P2:
                begin
                    // Effective only after the first of the pair
                    if (pair_q == cce_pkg::PAIR_FIRST)
                    begin
                        wdt_d = 1'b1;
                    end
                    pair_d = cce_pkg::PAIR_SECOND;
                end
                default:
                begin
                    // Idle or unknown code: nothing happens
                    pair_d = pair_q;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Plain register bank; all decisions are made in the block above.
    // Reset loads constants only, so its release is clean
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= cce_pkg::ST_EXEC;
            pair_q  <= cce_pkg::PAIR_NONE;
            push_q  <= 1'b0;
            stk_q   <= '0;
            pcl_q   <= 1'b0;
            pcv_q   <= '0;
            tgt_q   <= '0;
            we_q    <= 1'b0;
            wa_q    <= '0;
            wd_q    <= '0;
            wdt_q   <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            pair_q  <= pair_d;
            push_q  <= push_d;
            stk_q   <= stk_d;
            pcl_q   <= pcl_d;
            pcv_q   <= pcv_d;
            tgt_q   <= tgt_d;
            we_q    <= we_d;
            wa_q    <= wa_d;
            wd_q    <= wd_d;
            wdt_q   <= wdt_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Every output below comes straight from a flip-flop
    // Timeout and powerdown flag clears are driven from the same register as the watchdog restart
    assign stackPush        = push_q;
    assign stackData        = stk_q;
    assign pcLoad           = pcl_q;
    assign pcValue          = pcv_q;
    assign memWe            = we_q;
    assign memWaddr         = wa_q;
    assign memWdata         = wd_q;
    assign wdtRestart       = wdt_q;
    assign clrTimeoutFlag   = wdt_q;
    assign clrPowerdownFlag = wdt_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    // Each check looks one or two cycles past the op it starts from
    // Return point is the address after the call
    property p_call_push;
        @(posedge core_clk) disable iff (!rst_b)
        (accept && opCode == cce_pkg::OP_CALL) |=> stackPush
            && stackData == $past(curPc) + cce_pkg::RET_INC;
    endproperty
    a_call_push: assert property (p_call_push) else $error("call push wrong");

    // Second cycle after the take loads the held target
    property p_call_jump;
        @(posedge core_clk) disable iff (!rst_b)
        (accept && opCode == cce_pkg::OP_CALL) |=> ##1 pcLoad && pcValue == $past(callTarget, 2);
    endproperty
    a_call_jump: assert property (p_call_jump) else $error("call jump wrong");

    // Busy for exactly the one extra cycle
    property p_call_two;
        @(posedge core_clk) disable iff (!rst_b)
        (accept && opCode == cce_pkg::OP_CALL) |=> busy ##1 !busy;
    endproperty
    a_call_two: assert property (p_call_two) else $error("call not two cycles");

    // No condition can hold a call back
    property p_call_taken;
        @(posedge core_clk) disable iff (!rst_b)
        (opValid && !busy && opCode == cce_pkg::OP_CALL) |=> busy;
    endproperty
    a_call_taken: assert property (p_call_taken) else $error("call not taken");

    // Byte clear writes zero to the taken address
    property p_clr_byte;
        @(posedge core_clk) disable iff (!rst_b)
        (accept && opCode == cce_pkg::OP_CLR_BYTE) |=> memWe && memWdata == cce_pkg::BYTE_ZERO
            && memWaddr == $past(memAddr);
    endproperty
    a_clr_byte: assert property (p_clr_byte) else $error("clear byte wrong");

    // Only the chosen bit falls; the rest match the byte read
    property p_clr_bit;
        @(posedge core_clk) disable iff (!rst_b)
        (accept && opCode == cce_pkg::OP_CLR_BIT) |=> memWe
            && memWdata[$past(bitSel)] == 1'b0
            && (memWdata | (8'h01 << $past(bitSel))) == ($past(memRdata) | (8'h01 << $past(bitSel)));
    endproperty
    a_clr_bit: assert property (p_clr_bit) else $error("clear bit wrong");

    // Single clear pulses all three at once
    property p_wdt_one;
        @(posedge core_clk) disable iff (!rst_b)
        (accept && opCode == cce_pkg::OP_WDT_ONE) |=> wdtRestart && clrTimeoutFlag && clrPowerdownFlag;
    endproperty
    a_wdt_one: assert property (p_wdt_one) else $error("single clear missed");

    // First of the pair acts only after the second
    property p_pair_alt;
        @(posedge core_clk) disable iff (!rst_b)
        (accept && opCode == cce_pkg::OP_WDT_P1 && pair_q == cce_pkg::PAIR_SECOND) |=> wdtRestart;
    endproperty
    a_pair_alt: assert property (p_pair_alt) else $error("paired clear missed");

    // Second of the pair acts only after the first
    property p_pair_alt2;
        @(posedge core_clk) disable iff (!rst_b)
        (accept && opCode == cce_pkg::OP_WDT_P2 && pair_q == cce_pkg::PAIR_FIRST) |=> wdtRestart;
    endproperty
    a_pair_alt2: assert property (p_pair_alt2) else $error("paired clear missed");

    // First of the pair repeated, or first after reset, does nothing
    property p_pair_rep;
        @(posedge core_clk) disable iff (!rst_b)
        (accept && opCode == cce_pkg::OP_WDT_P1 && pair_q != cce_pkg::PAIR_SECOND) |=> !wdtRestart;
    endproperty
    a_pair_rep: assert property (p_pair_rep) else $error("repeat clear took effect");

    // Call and byte clear never clear the timeout flag
    property p_flags_only;
        @(posedge core_clk) disable iff (!rst_b)
        (accept && (opCode == cce_pkg::OP_CALL || opCode == cce_pkg::OP_CLR_BYTE)) |=> !clrTimeoutFlag;
    endproperty
    a_flags_only: assert property (p_flags_only) else $error("flag touched");

    // Second of the pair repeated, or first after reset, does nothing
    property p_pair_rep2;
        @(posedge core_clk) disable iff (!rst_b)
        (accept && opCode == cce_pkg::OP_WDT_P2 && pair_q != cce_pkg::PAIR_FIRST)
            |=> !wdtRestart;
    endproperty
    a_pair_rep2: assert property (p_pair_rep2) else $error("repeat clear took effect");

    // The block remembers which of the pair ran last
    property p_pair_mem;
        @(posedge core_clk) disable iff (!rst_b)
        (accept && (opCode == cce_pkg::OP_WDT_P1 || opCode == cce_pkg::OP_WDT_P2))
            |=> pair_q == (($past(opCode) == cce_pkg::OP_WDT_P1) ? cce_pkg::PAIR_FIRST
                                                                  : cce_pkg::PAIR_SECOND);
    endproperty
    a_pair_mem: assert property (p_pair_mem) else $error("pair memory wrong");

    // Ops offered while the call finishes are dropped without any effect
    property p_busy_drop;
        @(posedge core_clk) disable iff (!rst_b)
        (busy && opValid) |=> !memWe && !wdtRestart && !stackPush && !busy;
    endproperty
    a_busy_drop: assert property (p_busy_drop) else $error("op taken while busy");

    // Watchdog clears never write memory or touch the stack
    property p_wdt_quiet;
        @(posedge core_clk) disable iff (!rst_b)
        (accept && opCode inside {cce_pkg::OP_WDT_ONE, cce_pkg::OP_WDT_P1, cce_pkg::OP_WDT_P2})
            |=> !memWe && !stackPush && !busy;
    endproperty
    a_wdt_quiet: assert property (p_wdt_quiet) else $error("watchdog clear touched more");

    // Call and the memory clears leave the watchdog and both flags alone
    property p_flags_keep;
        @(posedge core_clk) disable iff (!rst_b)
        (accept && opCode inside {cce_pkg::OP_CALL, cce_pkg::OP_CLR_BYTE, cce_pkg::OP_CLR_BIT})
            |=> !wdtRestart && !clrTimeoutFlag && !clrPowerdownFlag;
    endproperty
    a_flags_keep: assert property (p_flags_keep) else $error("flag touched by clear");
endmodule
`default_nettype wire

// ==== hw/cce_pkg.sv ====
`default_nettype none
package cce_pkg;
    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int PC_W   = 11;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int BIT_W  = 3;

    // ----------------------------------------------------------------
    // Operation codes presented by decode
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_NONE     = 3'h0,
        OP_CALL     = 3'h1,
        OP_CLR_BYTE = 3'h2,
        OP_CLR_BIT  = 3'h3,
        OP_WDT_ONE  = 3'h4,
        OP_WDT_P1   = 3'h5,
        OP_WDT_P2   = 3'h6
    } cce_op_e;

    // Which paired clear ran last
    typedef enum logic [1:0] {
        PAIR_NONE   = 2'h0,
        PAIR_FIRST  = 2'h1,
        PAIR_SECOND = 2'h2
    } cce_pair_e;

    // One-hot execution states
    typedef enum logic [1:0] {
        ST_EXEC  = 2'h1,
        ST_CALL2 = 2'h2
    } cce_state_e;

    // Return point offset and cleared byte value
    localparam logic [PC_W-1:0]   RET_INC   = 11'h001;
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
endpackage
`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
    // --------------------
    // Design ports
    // --------------------
    logic               core_clk;
    logic               rst_b;
    logic               opValid;
    cce_pkg::cce_op_e   opCode;
    logic [10:0]        curPc, callTarget, stackData, pcValue;
    logic [7:0]         memAddr, memRdata, memWaddr, memWdata;
    logic [2:0]         bitSel;
    logic               busy, stackPush, pcLoad, memWe;
    logic               wdtRestart, clrTimeoutFlag, clrPowerdownFlag;
    // --------------------
    // Reference model
    // --------------------
    int                 errors;
    int                 compares;
    logic               mBusy;      // Call in its second cycle
    logic [10:0]        mTarget;    // Target held across the call
    cce_pkg::cce_pair_e mPair;      // Last paired clear seen
    logic               ePush, eLoad, eWe, eWdt;
    logic [10:0]        eStack, ePc;
    logic [7:0]         eAddr, eData;
    logic [15:0]        rnd;        // Shift register state
    // Pair orders, a drop while busy, a call cut by reset
    logic [2:0]         dirOps [11] = '{3'h5, 3'h5, 3'h6, 3'h6, 3'h5, 3'h4, 3'h1, 3'h2,
                                        3'h3, 3'h6, 3'h1};

    cce_exec i_dut
    (
        .core_clk(core_clk), .rst_b(rst_b), .opValid(opValid), .opCode(opCode),
        .curPc(curPc), .callTarget(callTarget), .memAddr(memAddr), .bitSel(bitSel),
        .memRdata(memRdata), .busy(busy), .stackPush(stackPush), .stackData(stackData),
        .pcLoad(pcLoad), .pcValue(pcValue), .memWe(memWe), .memWaddr(memWaddr),
        .memWdata(memWdata), .wdtRestart(wdtRestart), .clrTimeoutFlag(clrTimeoutFlag),
        .clrPowerdownFlag(clrPowerdownFlag)
    );

    // 250 MHz core clock
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // Sixteen-bit shift register; a cheap repeatable source
    function automatic logic [15:0] lfsrNext(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Compare with four-state equality so X matches only X
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic complete_run();
        if (errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Four-cycle reset; the model forgets pairing and any call
    task automatic applyReset();
        @(posedge core_clk);
        rst_b   <= 1'b0;
        opValid <= 1'b0;
        mBusy = 1'b0;
        mPair = cce_pkg::PAIR_NONE;
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
    endtask

    // One cycle: model what this edge took, drive next op, compare
    task automatic step(input logic v, input logic [2:0] op);
        @(posedge core_clk);
        {ePush, eLoad, eWe, eWdt} = 4'h0;
        if (mBusy)
        begin
            // Second call cycle: any op now is dropped
            eLoad = 1'b1;
            ePc   = mTarget;
            mBusy = 1'b0;
        end
        else if (opValid)
        begin
            case (opCode)
                cce_pkg::OP_CALL:
                begin
                    ePush   = 1'b1;
                    eStack  = curPc + 11'h001;
                    mTarget = callTarget;
                    mBusy   = 1'b1;
                end
                cce_pkg::OP_CLR_BYTE, cce_pkg::OP_CLR_BIT:
                begin
                    eWe   = 1'b1;
                    eAddr = memAddr;
                    eData = (opCode == cce_pkg::OP_CLR_BIT) ? memRdata & ~(8'h01 << bitSel) : 8'h00;
                end
                cce_pkg::OP_WDT_ONE: eWdt = 1'b1;
                cce_pkg::OP_WDT_P1:
                begin
                    eWdt  = (mPair == cce_pkg::PAIR_SECOND);
                    mPair = cce_pkg::PAIR_FIRST;
                end
                cce_pkg::OP_WDT_P2:
                begin
                    eWdt  = (mPair == cce_pkg::PAIR_FIRST);
                    mPair = cce_pkg::PAIR_SECOND;
                end
                default: ;
            endcase
        end
        rnd = lfsrNext(rnd);
        opValid    <= v;
        opCode     <= cce_pkg::cce_op_e'(op);
        curPc      <= rnd[10:0];
        bitSel     <= rnd[15:13];
        rnd = lfsrNext(rnd);
        callTarget <= rnd[10:0];
        rnd = lfsrNext(rnd);
        memAddr    <= rnd[7:0];
        memRdata   <= rnd[15:8];
        #2;
        check("busy", {15'h0, busy}, {15'h0, mBusy});
        check("stackPush", {15'h0, stackPush}, {15'h0, ePush});
        if (ePush) check("stackData", {5'h0, stackData}, {5'h0, eStack});
        check("pcLoad", {15'h0, pcLoad}, {15'h0, eLoad});
        if (eLoad) check("pcValue", {5'h0, pcValue}, {5'h0, ePc});
        check("memWe", {15'h0, memWe}, {15'h0, eWe});
        if (eWe) check("memWaddr", {8'h0, memWaddr}, {8'h0, eAddr});
        if (eWe) check("memWdata", {8'h0, memWdata}, {8'h0, eData});
        check("wdtRestart", {15'h0, wdtRestart}, {15'h0, eWdt});
        check("clrTimeoutFlag", {15'h0, clrTimeoutFlag}, {15'h0, eWdt});
        check("clrPowerdownFlag", {15'h0, clrPowerdownFlag}, {15'h0, eWdt});
    endtask

    // Twice over: directed pass, a reset cutting its last call short, then random pass
    initial
    begin
        rst_b = 1'b0;
        opValid = 1'b0;
        opCode = cce_pkg::OP_NONE;
        {curPc, callTarget, memAddr, bitSel, memRdata} = '0;
        errors = 0;
        compares = 0;
        rnd = 16'h0035;
        applyReset();
        repeat (2)
        begin
            foreach (dirOps[i]) step(1'b1, dirOps[i]);
            applyReset();
            repeat (1500)
            begin
                rnd = lfsrNext(rnd);
                step(rnd[0] | rnd[1], rnd[15:13]);
            end
        end
        complete_run();
    end

    // Hang guard: well beyond the three thousand cycles above
    initial
    begin
        #(4 * 5000);
        errors++;
        complete_run();
    end
endmodule
`default_nettype wire
